// *** core/psmc_pkg.sv ***
package psmc_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] PSMC_OFS_CTRL = 8'h00;
    localparam logic [7:0] PSMC_OFS_STRAP = 8'h04;
    localparam logic [7:0] PSMC_OFS_LINK = 8'h08;
    localparam logic [7:0] PSMC_OFS_INT_STAT = 8'h0c;
    localparam logic [7:0] PSMC_OFS_INT_CLR = 8'h10;
    localparam logic [7:0] PSMC_OFS_INT_EN = 8'h14;

    // port count and reset values
    localparam int PSMC_PORTS = 8;
    localparam logic [7:0] PSMC_CTRL_RST = 8'hff;
    localparam logic [9:0] PSMC_INT_EN_RST = 10'h000;

    // operating-mode strap codes
    localparam logic [2:0] PSMC_MODE_RMII_CODE = 3'h1;
    localparam logic [2:0] PSMC_MODE_SMII_CODE = 3'h2;
    localparam logic [2:0] PSMC_MODE_TEST_CODE = 3'h7;

    // interrupt status layout
    localparam int PSMC_IRQ_LINK_LSB = 0;
    localparam int PSMC_IRQ_SHORT_RST = 8;
    localparam int PSMC_IRQ_BAD_MODE = 9;
    localparam int PSMC_IRQ_W = 10;

    // strap readback layout
    localparam int PSMC_STRAP_MODE_LSB = 0;
    localparam int PSMC_STRAP_ADDR_LSB = 4;
    localparam int PSMC_STRAP_ENC_BIT = 8;
    localparam int PSMC_STRAP_SCR_BIT = 9;
    localparam int PSMC_STRAP_FLINK_BIT = 10;
    localparam int PSMC_STRAP_FPAT_BIT = 11;
    localparam int PSMC_STRAP_MDIX_BIT = 12;
    localparam int PSMC_STRAP_TEST_BIT = 13;

    // timing
    localparam int PSMC_CLK_MHZ = 50;
    localparam int PSMC_RESET_MIN_US = 500;
    localparam int PSMC_RESET_MIN_CYC = PSMC_RESET_MIN_US * PSMC_CLK_MHZ;

    // decoded operating mode
    typedef enum logic [1:0] {
        PSMC_MODE_NONE,
        PSMC_MODE_RMII,
        PSMC_MODE_SMII,
        PSMC_MODE_TEST
    } psmc_mode_t;

    // reset sequencing
    typedef enum logic [1:0] {
        PSMC_ST_RESET,
        PSMC_ST_LATCH,
        PSMC_ST_RUN
    } psmc_state_t;

endpackage

// *** core/psmc_port.sv ***
`timescale 1ns/10ps
`default_nettype none
module psmc_port
    import psmc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic speed_100_i,
    input wire logic line_ok_i,
    input wire logic crossed_i,
    input wire logic block_code_bypass_i,
    input wire logic scrambler_bypass_i,
    input wire logic force_link_up_i,
    input wire logic force_test_pattern_i,
    input wire logic crossover_auto_enable_i,
    output logic enc_bypass_o,
    output logic scr_bypass_o,
    output logic link_up_o,
    output logic pattern_tx_o,
    output logic pair_swap_o,
    output logic link_change_o
);

    logic enc_bypass_ff, nxt_enc_bypass;
    logic scr_bypass_ff, nxt_scr_bypass;
    logic link_up_ff, nxt_link_up;
    logic pattern_ff, nxt_pattern;
    logic swap_ff, nxt_swap;
    logic change_ff, nxt_change;

    // per-port datapath steering from straps
    always_comb
    begin
        nxt_enc_bypass = en_i & block_code_bypass_i & speed_100_i;
        nxt_scr_bypass = en_i & scrambler_bypass_i & speed_100_i;
        nxt_link_up = en_i & (force_link_up_i | line_ok_i);
        nxt_pattern = en_i & force_test_pattern_i & speed_100_i;
        nxt_swap = en_i & crossover_auto_enable_i & crossed_i;
        nxt_change = nxt_link_up ^ link_up_ff;
        if (clr_i)
        begin
            nxt_enc_bypass = 1'b0;
            nxt_scr_bypass = 1'b0;
            nxt_link_up = 1'b0;
            nxt_pattern = 1'b0;
            nxt_swap = 1'b0;
            nxt_change = 1'b0;
        end
    end

    // register per-port state
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            enc_bypass_ff <= 1'b0;
            scr_bypass_ff <= 1'b0;
            link_up_ff <= 1'b0;
            pattern_ff <= 1'b0;
            swap_ff <= 1'b0;
            change_ff <= 1'b0;
        end
        else
        begin
            enc_bypass_ff <= nxt_enc_bypass;
            scr_bypass_ff <= nxt_scr_bypass;
            link_up_ff <= nxt_link_up;
            pattern_ff <= nxt_pattern;
            swap_ff <= nxt_swap;
            change_ff <= nxt_change;
        end
    end

    assign enc_bypass_o = enc_bypass_ff;
    assign scr_bypass_o = scr_bypass_ff;
    assign link_up_o = link_up_ff;
    assign pattern_tx_o = pattern_ff;
    assign pair_swap_o = swap_ff;
    assign link_change_o = change_ff;

endmodule
`default_nettype wire

// *** core/psmc_top.sv ***
// What this block does
// - mode select 001 runs all ports in RMII, master clock 50 MHz.
// - mode select 010 runs all ports in SMII, master clock 125 MHz.
// - device reset input is active high; all but the width counter and read data held reset while high.
// - upper two PHY address bits come from address straps, default low.
// - link status change on any port drives open-drain interrupt.
// - block-code bypass strap skips 4B/5B coding on 100 Mbps ports.
// - scrambler bypass strap skips scrambler/descrambler on 100 Mbps ports.
// - force-link strap reports good link regardless of line signal.
// - force-pattern strap sends 34 test pattern, only at 100M.
// - crossover enable (default high) swaps pairs on detected crossing.
// - factory test input enters manufacturing test mode, like mode 111.
// - test-execute input enters async test mode, like mode 111.
`timescale 1ns/10ps
`default_nettype none
module psmc_top
    import psmc_pkg::*;
#(
    parameter int RESET_MIN_CYC = PSMC_RESET_MIN_CYC,
    parameter int PORTS = PSMC_PORTS
)
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic dev_reset_i,
    input wire logic [2:0] mode_sel_i,
    input wire logic [1:0] phy_addr_upper_straps_i,
    input wire logic block_code_bypass_i,
    input wire logic scrambler_bypass_i,
    input wire logic force_link_up_i,
    input wire logic force_test_pattern_i,
    input wire logic crossover_auto_enable_i,
    input wire logic factory_test_in_i,
    input wire logic async_test_exec_i,
    input wire logic test_clk_i,
    input wire logic [PORTS-1:0] port_speed_100_i,
    input wire logic [PORTS-1:0] line_link_ok_i,
    input wire logic [PORTS-1:0] cable_crossed_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic rmii_mode_o,
    output logic smii_mode_o,
    output logic test_mode_o,
    output logic mfg_test_o,
    output logic async_test_o,
    output logic [1:0] phy_addr_upper_o,
    output logic [PORTS-1:0] enc_bypass_o,
    output logic [PORTS-1:0] scr_bypass_o,
    output logic [PORTS-1:0] link_up_o,
    output logic [PORTS-1:0] pattern_tx_o,
    output logic [PORTS-1:0] pair_swap_o,
    output logic irq_o,
    output logic int_n_out_o,
    output logic int_n_oe_o,
    output logic test_result_out_o,
    output logic in_reset_o
);

    localparam int RCW = $clog2(RESET_MIN_CYC + 1);
    localparam logic [RCW-1:0] RC_MAX = RCW'(RESET_MIN_CYC);

    // system reset release through two flops
    logic [1:0] rst_sync_ff;
    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rst_sync_ff <= 2'h0;
        else
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
    logic rst_n;
    assign rst_n = rst_sync_ff[1];

    // reset sequencing and strap capture state
    psmc_state_t state_ff, nxt_state;
    logic [RCW-1:0] rcnt_ff, nxt_rcnt;
    logic short_ev_ff, nxt_short_ev;
    logic [2:0] mode_ff, nxt_mode;
    logic [1:0] addr_ff, nxt_addr;
    logic enc_ff, nxt_enc;
    logic scr_ff, nxt_scr;
    logic flink_ff, nxt_flink;
    logic fpat_ff, nxt_fpat;
    logic mdix_ff, nxt_mdix;
    logic running;
    assign running = (state_ff == PSMC_ST_RUN);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_rcnt = rcnt_ff;
        nxt_short_ev = 1'b0;
        nxt_mode = mode_ff;
        nxt_addr = addr_ff;
        nxt_enc = enc_ff;
        nxt_scr = scr_ff;
        nxt_flink = flink_ff;
        nxt_fpat = fpat_ff;
        nxt_mdix = mdix_ff;
        unique case (state_ff)
            PSMC_ST_RESET:
            begin
                // measure reset width, saturating
                if (rcnt_ff != RC_MAX)
                    nxt_rcnt = rcnt_ff + 1'b1;
                if (!dev_reset_i)
                begin
                    nxt_state = PSMC_ST_LATCH;
                    nxt_short_ev = (rcnt_ff != RC_MAX);
                end
            end
            PSMC_ST_LATCH:
            begin
                // straps taken once, right after release
                nxt_mode = mode_sel_i;
                nxt_addr = phy_addr_upper_straps_i;
                nxt_enc = block_code_bypass_i;
                nxt_scr = scrambler_bypass_i;
                nxt_flink = force_link_up_i;
                nxt_fpat = force_test_pattern_i;
                nxt_mdix = crossover_auto_enable_i;
                nxt_state = PSMC_ST_RUN;
            end
            PSMC_ST_RUN:
                nxt_state = PSMC_ST_RUN;
            default:
                nxt_state = PSMC_ST_RESET;
        endcase
        if (dev_reset_i)
        begin
            nxt_state = PSMC_ST_RESET;
            // the first high cycle already counts toward the width
            if (state_ff != PSMC_ST_RESET)
                nxt_rcnt = RCW'(1);
            else if (rcnt_ff != RC_MAX)
                nxt_rcnt = rcnt_ff + 1'b1;
            nxt_mode = 3'h0;
            nxt_addr = 2'h0;
            nxt_enc = 1'b0;
            nxt_scr = 1'b0;
            nxt_flink = 1'b0;
            nxt_fpat = 1'b0;
            nxt_mdix = 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= PSMC_ST_RESET;
            rcnt_ff <= RC_MAX;
            short_ev_ff <= 1'b0;
            mode_ff <= 3'h0;
            addr_ff <= 2'h0;
            enc_ff <= 1'b0;
            scr_ff <= 1'b0;
            flink_ff <= 1'b0;
            fpat_ff <= 1'b0;
            mdix_ff <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
            rcnt_ff <= nxt_rcnt;
            short_ev_ff <= nxt_short_ev;
            mode_ff <= nxt_mode;
            addr_ff <= nxt_addr;
            enc_ff <= nxt_enc;
            scr_ff <= nxt_scr;
            flink_ff <= nxt_flink;
            fpat_ff <= nxt_fpat;
            mdix_ff <= nxt_mdix;
        end
    end

    // mode decode and test entry
    psmc_mode_t mode_dec;
    logic tst_req;
    always_comb
    begin
        tst_req = factory_test_in_i | async_test_exec_i;
        unique case (mode_ff)
            PSMC_MODE_RMII_CODE: mode_dec = PSMC_MODE_RMII;
            PSMC_MODE_SMII_CODE: mode_dec = PSMC_MODE_SMII;
            PSMC_MODE_TEST_CODE: mode_dec = PSMC_MODE_TEST;
            default: mode_dec = PSMC_MODE_NONE;
        endcase
        if (tst_req)
            mode_dec = PSMC_MODE_TEST;
    end

    // registered mode outputs
    logic rmii_ff, smii_ff, test_ff, mfg_ff, atest_ff, bad_mode_ff;
    logic nxt_rmii, nxt_smii, nxt_test, nxt_mfg, nxt_atest, nxt_bad_mode;
    always_comb
    begin
        nxt_rmii = running & (mode_dec == PSMC_MODE_RMII);
        nxt_smii = running & (mode_dec == PSMC_MODE_SMII);
        nxt_test = running & (mode_dec == PSMC_MODE_TEST);
        nxt_mfg = running & factory_test_in_i;
        nxt_atest = running & async_test_exec_i;
        nxt_bad_mode = (state_ff == PSMC_ST_LATCH)
            & (mode_sel_i != PSMC_MODE_RMII_CODE)
            & (mode_sel_i != PSMC_MODE_SMII_CODE)
            & (mode_sel_i != PSMC_MODE_TEST_CODE);
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rmii_ff <= 1'b0;
            smii_ff <= 1'b0;
            test_ff <= 1'b0;
            mfg_ff <= 1'b0;
            atest_ff <= 1'b0;
            bad_mode_ff <= 1'b0;
        end
        else
        begin
            rmii_ff <= nxt_rmii;
            smii_ff <= nxt_smii;
            test_ff <= nxt_test;
            mfg_ff <= nxt_mfg;
            atest_ff <= nxt_atest;
            bad_mode_ff <= nxt_bad_mode;
        end
    end

    // register file state
    logic [PORTS-1:0] port_en_ff, nxt_port_en;
    logic [PSMC_IRQ_W-1:0] int_stat_ff, nxt_int_stat;
    logic [PSMC_IRQ_W-1:0] int_en_ff, nxt_int_en;
    logic [31:0] rdata_ff, nxt_rdata;
    logic irq_ff, nxt_irq;
    logic test_result_out_ff, nxt_test_result_out;
    logic [PORTS-1:0] link_chg;
    logic [PORTS-1:0] link_up;
    logic [PSMC_IRQ_W-1:0] ev;
    logic [31:0] strap_rd;

    // eight identical port slices
    genvar gp;
    generate
        for (gp = 0; gp < PORTS; gp++)
        begin : g_port
            psmc_port u_port (
                .clk_i(clk_i),
                .rst_n_i(rst_n),
                .clr_i(dev_reset_i),
                .en_i(running & port_en_ff[gp]),
                .speed_100_i(port_speed_100_i[gp]),
                .line_ok_i(line_link_ok_i[gp]),
                .crossed_i(cable_crossed_i[gp]),
                .block_code_bypass_i(enc_ff),
                .scrambler_bypass_i(scr_ff),
                .force_link_up_i(flink_ff),
                .force_test_pattern_i(fpat_ff),
                .crossover_auto_enable_i(mdix_ff),
                .enc_bypass_o(enc_bypass_o[gp]),
                .scr_bypass_o(scr_bypass_o[gp]),
                .link_up_o(link_up[gp]),
                .pattern_tx_o(pattern_tx_o[gp]),
                .pair_swap_o(pair_swap_o[gp]),
                .link_change_o(link_chg[gp])
            );
        end
    endgenerate
    assign link_up_o = link_up;

    // strap readback word
    always_comb
    begin
        strap_rd = 32'h0;
        strap_rd[PSMC_STRAP_MODE_LSB +: 3] = mode_ff;
        strap_rd[PSMC_STRAP_ADDR_LSB +: 2] = addr_ff;
        strap_rd[PSMC_STRAP_ENC_BIT] = enc_ff;
        strap_rd[PSMC_STRAP_SCR_BIT] = scr_ff;
        strap_rd[PSMC_STRAP_FLINK_BIT] = flink_ff;
        strap_rd[PSMC_STRAP_FPAT_BIT] = fpat_ff;
        strap_rd[PSMC_STRAP_MDIX_BIT] = mdix_ff;
        strap_rd[PSMC_STRAP_TEST_BIT] = test_ff;
    end

    // register writes, sticky status, read mux, interrupt
    always_comb
    begin
        ev = '0;
        ev[PSMC_IRQ_LINK_LSB +: PORTS] = link_chg;
        ev[PSMC_IRQ_SHORT_RST] = short_ev_ff;
        ev[PSMC_IRQ_BAD_MODE] = bad_mode_ff;
        nxt_port_en = port_en_ff;
        nxt_int_en = int_en_ff;
        nxt_int_stat = int_stat_ff;
        if (reg_wr_i && reg_addr_i == PSMC_OFS_CTRL)
            nxt_port_en = reg_wdata_i[PORTS-1:0];
        if (reg_wr_i && reg_addr_i == PSMC_OFS_INT_EN)
            nxt_int_en = reg_wdata_i[PSMC_IRQ_W-1:0];
        if (reg_wr_i && reg_addr_i == PSMC_OFS_INT_CLR)
            nxt_int_stat = int_stat_ff & ~reg_wdata_i[PSMC_IRQ_W-1:0];
        nxt_int_stat = nxt_int_stat | ev; // set wins over clear
        nxt_rdata = 32'h0;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                PSMC_OFS_CTRL: nxt_rdata[PORTS-1:0] = port_en_ff;
                PSMC_OFS_STRAP: nxt_rdata = strap_rd;
                PSMC_OFS_LINK: nxt_rdata[PORTS-1:0] = link_up;
                PSMC_OFS_INT_STAT: nxt_rdata[PSMC_IRQ_W-1:0] = int_stat_ff;
                PSMC_OFS_INT_EN: nxt_rdata[PSMC_IRQ_W-1:0] = int_en_ff;
                default: nxt_rdata = 32'h0;
            endcase
        end
        if (dev_reset_i)
        begin
            nxt_port_en = PORTS'(PSMC_CTRL_RST);
            nxt_int_en = PSMC_INT_EN_RST;
            nxt_int_stat = '0;
        end
        nxt_irq = |(nxt_int_stat & nxt_int_en);
        nxt_test_result_out = test_ff & (^link_up ^ test_clk_i);
    end

    always_ff @(posedge clk_i or negedge rst_n)
    begin
        if (!rst_n)
        begin
            port_en_ff <= PORTS'(PSMC_CTRL_RST);
            int_en_ff <= PSMC_INT_EN_RST;
            int_stat_ff <= '0;
            rdata_ff <= 32'h0;
            irq_ff <= 1'b0;
            test_result_out_ff <= 1'b0;
        end
        else
        begin
            port_en_ff <= nxt_port_en;
            int_en_ff <= nxt_int_en;
            int_stat_ff <= nxt_int_stat;
            rdata_ff <= nxt_rdata;
            irq_ff <= nxt_irq;
            test_result_out_ff <= nxt_test_result_out;
        end
    end

    // outputs
    assign reg_rdata_o = rdata_ff;
    assign rmii_mode_o = rmii_ff;
    assign smii_mode_o = smii_ff;
    assign test_mode_o = test_ff;
    assign mfg_test_o = mfg_ff;
    assign async_test_o = atest_ff;
    assign phy_addr_upper_o = addr_ff;
    assign irq_o = irq_ff;
    assign int_n_out_o = 1'b0; // open drain only pulls low
    assign int_n_oe_o = irq_ff;
    assign test_result_out_o = test_result_out_ff;
    assign in_reset_o = ~running;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    sequence s_release;
        dev_reset_i ##1 !dev_reset_i;
    endsequence
    sequence s_latched;
        ##2 (mode_ff == $past(mode_sel_i)
            && addr_ff == $past(phy_addr_upper_straps_i));
    endsequence

    property p_rmii;
        running && mode_ff == PSMC_MODE_RMII_CODE && !tst_req |=> rmii_mode_o;
    endproperty
    a_rmii: assert property (p_rmii) else $error("rmii not set");

    property p_smii;
        running && mode_ff == PSMC_MODE_SMII_CODE && !tst_req |=> smii_mode_o;
    endproperty
    a_smii: assert property (p_smii) else $error("smii not set");

    property p_reset_hold;
        dev_reset_i |=> !running && link_up_o == '0 && !irq_o;
    endproperty
    a_reset_hold: assert property (p_reset_hold) else $error("reset ignored");

    property p_latch;
        s_release |-> s_latched;
    endproperty
    a_latch: assert property (p_latch) else $error("straps not latched");

    property p_static;
        running && !dev_reset_i |=> $stable(mode_ff) && $stable(addr_ff);
    endproperty
    a_static: assert property (p_static) else $error("strap moved");

    property p_irq;
        |(int_stat_ff & int_en_ff) |-> irq_o && int_n_oe_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_pattern;
        pattern_tx_o != '0 |-> fpat_ff && ((pattern_tx_o & ~$past(port_speed_100_i)) == '0);
    endproperty
    a_pattern: assert property (p_pattern) else $error("pattern at 10M");

    property p_flink;
        running && flink_ff && port_en_ff[0] && !dev_reset_i ##1 !dev_reset_i |-> link_up_o[0];
    endproperty
    a_flink: assert property (p_flink) else $error("link not forced");

    property p_test;
        running && factory_test_in_i && !dev_reset_i |=> test_mode_o && mfg_test_o;
    endproperty
    a_test: assert property (p_test) else $error("test mode missed");

    property p_encbyp;
        enc_bypass_o[0] |-> enc_ff && $past(port_speed_100_i[0]);
    endproperty
    a_encbyp: assert property (p_encbyp) else $error("bad bypass");

endmodule
`default_nettype wire

// *** tb/psmc_board.sv ***
`timescale 1ns/10ps
`default_nettype none
module psmc_board
(
    input wire logic clk_i,
    input wire logic [7:0] len_i,
    input wire logic [1:0] test_i,
    output logic dev_reset_o,
    output logic factory_test_in_o,
    output logic async_test_exec_o,
    output logic test_clk_o
);
    logic [7:0] cnt_ff = 8'h00;
    // reset pulse of the asked width, counted down
    always_ff @(posedge clk_i)
    begin
        if (len_i != 8'h00)
            cnt_ff <= len_i;
        else if (cnt_ff != 8'h00)
            cnt_ff <= cnt_ff - 8'h01;
    end
    assign dev_reset_o = (cnt_ff != 8'h00);
    // test pins stay low unless a test is asked for
    assign factory_test_in_o = test_i[0];
    assign async_test_exec_o = test_i[1];
    assign test_clk_o = 1'b0;
endmodule
`default_nettype wire

// *** tb/tb_phy_strap_mode_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_phy_strap_mode_control
    import psmc_pkg::*;
;
    localparam int RMIN = 8;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] blen = 8'h00;
    logic [1:0] tst = 2'h0;
    logic [2:0] mode = 3'h1;
    logic [1:0] addr = 2'h0;
    logic [4:0] sp = 5'h10;
    logic [7:0] spd = 8'h00;
    logic [7:0] lok = 8'h00;
    logic [7:0] crs = 8'h00;
    logic [7:0] ra = 8'h00;
    logic [31:0] wd = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic drst, fti, ate, tck;
    logic [31:0] rdat, d;
    logic rmii, smii, tmode, mfg, atst, irq, int_n_out, ioe, test_result_out, inr;
    logic [1:0] pa;
    logic [7:0] encb, scrb, lup, pat, swp;
    int err_total = 0;
    int check_count = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    psmc_board u_psmc_board (.clk_i(clk), .len_i(blen), .test_i(tst),
        .dev_reset_o(drst), .factory_test_in_o(fti),
        .async_test_exec_o(ate), .test_clk_o(tck));

    psmc_top #(.RESET_MIN_CYC(RMIN)) u_psmc_top (.clk_i(clk),
        .rst_n_i(rst_n), .dev_reset_i(drst), .mode_sel_i(mode),
        .phy_addr_upper_straps_i(addr), .block_code_bypass_i(sp[0]),
        .scrambler_bypass_i(sp[1]), .force_link_up_i(sp[2]),
        .force_test_pattern_i(sp[3]), .crossover_auto_enable_i(sp[4]),
        .factory_test_in_i(fti), .async_test_exec_i(ate),
        .test_clk_i(tck), .port_speed_100_i(spd), .line_link_ok_i(lok),
        .cable_crossed_i(crs), .reg_addr_i(ra), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .rmii_mode_o(rmii), .smii_mode_o(smii), .test_mode_o(tmode),
        .mfg_test_o(mfg), .async_test_o(atst), .phy_addr_upper_o(pa),
        .enc_bypass_o(encb), .scr_bypass_o(scrb), .link_up_o(lup),
        .pattern_tx_o(pat), .pair_swap_o(swp), .irq_o(irq),
        .int_n_out_o(int_n_out), .int_n_oe_o(ioe),
        .test_result_out_o(test_result_out), .in_reset_o(inr));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // wait n edges, then let outputs settle
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        ra <= a;
        wd <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdat;
    endtask

    // device reset pulse, then wait for the run state
    task automatic dreset(input logic [7:0] n);
        @(posedge clk);
        blen <= n;
        @(posedge clk);
        blen <= 8'h00;
        cyc(3);
        chk(32'({inr, lup}), 32'h100);
        for (int i = 0; i < 100 && inr !== 1'b0; i++)
            @(posedge clk);
        cyc(2);
        chk(32'(inr), 32'h0);
    endtask

    task automatic t_modes();
        logic [2:0] c [4] = '{3'h1, 3'h2, 3'h7, 3'h0};
        logic [2:0] e [4] = '{3'h4, 3'h2, 3'h1, 3'h0};
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            mode <= c[i];
            dreset(8'(RMIN));
            chk(32'({rmii, smii, tmode}), 32'(e[i]));
            rreg(PSMC_OFS_STRAP);
            chk(32'(d[2:0]), 32'(c[i]));
            rreg(PSMC_OFS_INT_STAT);
            chk(d & 32'h300, (i == 3) ? 32'h200 : 32'h0);
            @(posedge clk);
            mode <= ~c[i];
            cyc(3);
            chk(32'({rmii, smii, tmode}), 32'(e[i]));
        end
    endtask

    task automatic t_straps();
        @(posedge clk);
        mode <= 3'h1;
        addr <= 2'h2;
        sp <= 5'h0f;
        spd <= 8'h0f;
        crs <= 8'hff;
        dreset(8'(RMIN));
        chk(32'(pa), 32'h2);
        chk(32'(encb), 32'h0f);
        chk(32'(scrb), 32'h0f);
        chk(32'(lup), 32'hff);
        chk(32'(pat), 32'h0f);
        chk(32'(swp), 32'h00);
        @(posedge clk);
        sp <= 5'h10;
        addr <= 2'h0;
        lok <= 8'h3c;
        crs <= 8'h55;
        cyc(3);
        chk(32'({pa, encb, lup}), 32'h20fff);
        rreg(PSMC_OFS_CTRL);
        chk(d, 32'hff);
        wreg(PSMC_OFS_CTRL, 32'hfe);
        cyc(3);
        chk(32'(lup[0]), 32'h0);
        dreset(8'(RMIN));
        chk(32'(pa), 32'h0);
        chk(32'(lup), 32'h3c);
        chk(32'(swp), 32'h55);
        chk(32'({encb, scrb, pat}), 32'h0);
    endtask

    task automatic t_irq();
        wreg(PSMC_OFS_INT_CLR, 32'h3ff);
        wreg(PSMC_OFS_INT_EN, 32'h001);
        @(posedge clk);
        lok <= 8'h3d;
        cyc(4);
        chk(32'({irq, ioe, int_n_out}), 32'h6);
        rreg(PSMC_OFS_INT_STAT);
        chk(d, 32'h001);
        @(posedge clk);
        lok <= 8'h3f;
        cyc(4);
        wreg(PSMC_OFS_INT_CLR, 32'h001);
        cyc(2);
        chk(32'({irq, ioe}), 32'h0);
        rreg(PSMC_OFS_INT_STAT);
        chk(d, 32'h002);
        rreg(PSMC_OFS_INT_CLR);
        chk(d, 32'h0);
        rreg(8'h40);
        chk(d, 32'h0);
        rreg(PSMC_OFS_INT_EN);
        chk(d, 32'h001);
    endtask

    task automatic t_test();
        dreset(8'h03);
        rreg(PSMC_OFS_INT_STAT);
        chk(d & 32'h300, 32'h100);
        @(posedge clk);
        tst <= 2'h1;
        cyc(3);
        chk(32'({tmode, mfg, atst}), 32'h6);
        chk(32'(test_result_out), 32'h0);
        @(posedge clk);
        tst <= 2'h2;
        cyc(3);
        chk(32'({tmode, mfg, atst}), 32'h5);
        @(posedge clk);
        tst <= 2'h0;
        cyc(3);
        chk(32'({rmii, tmode}), 32'h2);
    endtask

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cyc(6);
        t_modes();
        t_straps();
        t_irq();
        t_test();
        complete_run();
    end

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        complete_run();
    end
endmodule
`default_nettype wire
